// File: hw/fsg_pkg.sv
// Purpose: constants for the self-programming guard block
// Assumes: 100 MHz mclk_i, 32-bit AXI4-Lite register bus
// Notes:   offsets are byte addresses of aligned words
package fsg_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00; // selfprog_control_status
  localparam logic [7:0] OFF_ZPTR     = 8'h04; // flash address pointer
  localparam logic [7:0] OFF_EVENT    = 8'h08; // cpu instruction strobes
  localparam logic [7:0] OFF_RESULT   = 8'h0c; // load result
  localparam logic [7:0] OFF_FUSES    = 8'h10; // fuse/lock values (programmed = 0)
  localparam logic [7:0] OFF_IRQ_STAT = 8'h14; // sticky events
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18; // event mask
  localparam logic [7:0] OFF_EEPROM   = 8'h1c; // eeprom_control
  // control field positions
  localparam int B_SELFPROG_ENABLE = 0;
  localparam int B_PAGE_ERASE      = 1;
  localparam int B_PAGE_WRITE      = 2;
  localparam int B_LOCK_SET        = 3;
  localparam int B_RWW_READ_EN     = 4;
  localparam int B_RWW_BUSY        = 6;
  // event register bits
  localparam int B_EV_LOAD  = 0;
  localparam int B_EV_STORE = 1;
  // interrupt status bits
  localparam int B_IRQ_DONE    = 0;
  localparam int B_IRQ_REFUSED = 1;
  localparam int B_IRQ_EXPIRED = 2;
  // readback pointer codes
  localparam logic [15:0] Z_FUSE_LOW  = 16'h0000;
  localparam logic [15:0] Z_LOCK      = 16'h0001;
  localparam logic [15:0] Z_FUSE_EXT  = 16'h0002;
  localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;
  // timed-sequence windows, in cycles
  localparam logic [2:0] LOAD_WINDOW  = 3'h3;
  localparam logic [2:0] STORE_WINDOW = 3'h4;
  // flash operation time from the rc oscillator
  localparam int CLK_MHZ      = 100;
  localparam int PROG_MIN_US  = 3700;
  localparam int PROG_MAX_US  = 4500;
  localparam int PROG_TIME_US = (PROG_MIN_US + PROG_MAX_US) / 2;
  localparam int PROG_CYCLES  = PROG_TIME_US * CLK_MHZ;
  localparam logic [7:0] UNDEF_READ = 8'hff;   // answer to unknown pointer
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    FSG_IDLE = 2'b00,
    FSG_ARMED = 2'b01,
    FSG_PROG = 2'b10
  } fsg_state_type;
endpackage

// File: hw/fsg_prog_timer.sv
// Purpose: flash operation timer counting system clock cycles
// Assumes: start is a one-cycle pulse; separate reset keeps it alive
// Notes:   done pulses once when the count runs out
`timescale 1ns/1ns
module fsg_prog_timer #(
  parameter int CYCLES = 410000
) (
  input  wire logic mclk_i,    // system clock
  input  wire logic por_n_i,   // power-on reset only, active low
  input  wire logic start_i,   // begin an operation
  output logic      busy_o,    // operation running
  output logic      done_o     // end pulse
);
  logic [31:0] count;
  // count down; reset of the core does not reach this counter
  always_ff @(posedge mclk_i or negedge por_n_i) begin
    if (!por_n_i) begin
      count  <= 32'h0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy_o) begin
        count  <= 32'(CYCLES - 1);
        busy_o <= 1'b1;
      end else if (busy_o) begin
        if (count == 32'h0) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          count <= count - 32'h1;
        end
      end
    end
  end
endmodule // fsg_prog_timer

// File: hw/fsg_guard.sv
// Purpose: self-programming guard with fuse/lock readback and flash timing
// Assumes: cpu model posts load/store strobes through the event register
// Notes:   one AXI4-Lite slave; one write and one read at a time
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
module fsg_guard
  import fsg_pkg::*;
(
  input  wire logic        mclk_i,        // system clock
  input  wire logic        resetn_i,      // system reset, active low
  input  wire logic        por_n_i,       // power-on reset, active low
  input  wire logic [7:0]  s_awaddr_i,    // write address
  input  wire logic        s_awvalid_i,   // write address valid
  output logic             s_awready_o,   // write address ready
  input  wire logic [31:0] s_wdata_i,     // write data
  input  wire logic [3:0]  s_wstrb_i,     // write strobes
  input  wire logic        s_wvalid_i,    // write data valid
  output logic             s_wready_o,    // write data ready
  output logic [1:0]       s_bresp_o,     // write response
  output logic             s_bvalid_o,    // write response valid
  input  wire logic        s_bready_i,    // write response ready
  input  wire logic [7:0]  s_araddr_i,    // read address
  input  wire logic        s_arvalid_i,   // read address valid
  output logic             s_arready_o,   // read address ready
  output logic [31:0]      s_rdata_o,     // read data
  output logic [1:0]       s_rresp_o,     // read response
  output logic             s_rvalid_o,    // read data valid
  input  wire logic        s_rready_i,    // read data ready
  input  wire logic [7:0]  flash_data_i,  // ordinary program memory byte
  output logic             flash_erase_o, // page erase strobe to array
  output logic             flash_write_o, // page write strobe to array
  output logic             rww_block_o,   // section unreadable
  output logic             irq_o          // level interrupt
);
  fsg_state_type state;
  logic [7:0]  ctrl;
  logic [15:0] zptr;
  logic [7:0]  result;
  logic [31:0] fuses;      // lock, low, high, ext bytes
  logic [2:0]  irq_stat;
  logic [2:0]  irq_mask;
  logic        ee_pending;
  logic [2:0]  window;
  logic        rww_busy;
  logic        readback;   // armed for a lock/fuse read
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic        ev_load;
  logic        ev_store;
  logic        ctrl_wr;
  logic        ev_done;
  logic        ev_refused;
  logic        ev_expired;
  logic        t_start;
  logic        t_busy;
  logic        t_done;
  logic [7:0]  next_result;

  // write channel capture; address and data may come in either order
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h0;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
    end else begin
      if (s_awvalid_i && s_awready_o) begin
        aw_held <= 1'b1;
        aw_addr <= s_awaddr_i;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_wvalid_i && s_wready_o) begin
        w_held <= 1'b1;
        w_data <= s_wdata_i;
        w_strb <= s_wstrb_i;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  assign do_write   = aw_held && w_held && !s_bvalid_o;
  assign ctrl_wr    = do_write && aw_addr == OFF_CTRL && w_strb[0];
  assign ev_load    = do_write && aw_addr == OFF_EVENT && w_strb[0] && w_data[B_EV_LOAD];
  assign ev_store   = do_write && aw_addr == OFF_EVENT && w_strb[0] && w_data[B_EV_STORE];

  // ready and response registers
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_awready_o <= 1'b0;
      s_wready_o  <= 1'b0;
      s_bvalid_o  <= 1'b0;
      s_bresp_o   <= RESP_OKAY;
    end else begin
      s_awready_o <= !aw_held && !(s_awvalid_i && s_awready_o);
      s_wready_o  <= !w_held && !(s_wvalid_i && s_wready_o);
      if (do_write) begin
        s_bvalid_o <= 1'b1;
        s_bresp_o  <= (aw_addr <= OFF_EEPROM) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_bready_i) begin
        s_bvalid_o <= 1'b0;
      end
    end
  end

  // pointer, fuse values, eeprom flag and mask
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      zptr       <= 16'h0;
      fuses      <= 32'hffffffff;
      ee_pending <= 1'b0;
      irq_mask   <= 3'h0;
    end else if (do_write) begin
      case (aw_addr)
        OFF_ZPTR:     zptr       <= w_data[15:0];
        OFF_FUSES:    fuses      <= w_data;
        OFF_EEPROM:   ee_pending <= w_data[0];
        OFF_IRQ_MASK: irq_mask   <= w_data[2:0];
        default:      zptr       <= zptr;
      endcase
    end
  end

  // readback mux; programmed fuse bits are stored as zero already
  always_comb begin
    next_result = UNDEF_READ;
    case (zptr)
      Z_LOCK:      next_result = fuses[7:0];
      Z_FUSE_LOW:  next_result = fuses[15:8];
      Z_FUSE_HIGH: next_result = fuses[23:16];
      Z_FUSE_EXT:  next_result = {4'hf, fuses[27:24]};
      default:     next_result = UNDEF_READ;
    endcase
  end

  // timed-sequence state machine
  assign readback = ctrl[B_LOCK_SET] && ctrl[B_SELFPROG_ENABLE] && state == FSG_ARMED;
  // a start while the timer still runs (after a system reset) would be lost
  assign t_start  = state == FSG_ARMED && ev_store && !ee_pending && !t_busy
                    && (ctrl[B_PAGE_ERASE] || ctrl[B_PAGE_WRITE] || ctrl[B_LOCK_SET]);
  assign ev_refused = state == FSG_ARMED && (ev_store || (ev_load && readback))
                      && ee_pending;
  // a readback expires one cycle after its load window, a command one cycle after the store window
  assign ev_expired = state == FSG_ARMED && !ev_load && !ev_store
                      && (window == 3'h0
                          || (readback && window == STORE_WINDOW - LOAD_WINDOW));
  assign ev_done    = t_done;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state  <= FSG_IDLE;
      ctrl   <= 8'h0;
      window <= 3'h0;
      result <= 8'h0;
    end else begin
      case (state)
        FSG_IDLE: begin
          if (ctrl_wr && w_data[B_SELFPROG_ENABLE]) begin
            ctrl   <= {1'b0, 1'b0, 1'b0, w_data[4:0]};
            window <= STORE_WINDOW;
            state  <= FSG_ARMED;
          end
          if (ev_load) begin
            result <= flash_data_i;
          end
        end
        FSG_ARMED: begin
          window <= window - 3'h1;
          if (ev_refused) begin
            ctrl  <= 8'h0;
            state <= FSG_IDLE;
          end else if (ev_load && readback && window > STORE_WINDOW - LOAD_WINDOW) begin
            result <= next_result;
            ctrl   <= 8'h0;
            state  <= FSG_IDLE;
          end else if (t_start) begin
            state <= FSG_PROG;
          end else if (ev_store) begin
            ctrl  <= 8'h0;                              // rww re-enable or buffer load
            state <= FSG_IDLE;
          end else if (ev_expired || (readback && window == STORE_WINDOW - LOAD_WINDOW)) begin
            ctrl  <= 8'h0;
            state <= FSG_IDLE;
          end else if (ev_load) begin
            result <= flash_data_i;
          end
        end
        FSG_PROG: begin
          if (t_done) begin
            ctrl  <= 8'h0;
            state <= FSG_IDLE;
          end
        end
        default: state <= FSG_IDLE;
      endcase
    end
  end

  // busy flag survives the system reset, cleared by re-enable store
  always_ff @(posedge mclk_i or negedge por_n_i) begin
    if (!por_n_i) begin
      rww_busy <= 1'b0;
    end else if (t_start && !ctrl[B_LOCK_SET]) begin
      rww_busy <= 1'b1;
    end else if (!t_busy && state == FSG_ARMED && ev_store && !ee_pending
                 && ctrl[B_RWW_READ_EN]) begin
      rww_busy <= 1'b0;
    end
  end

  // operation timer on the power-on reset only
  fsg_prog_timer #(
    .CYCLES (PROG_CYCLES)
  ) u_timer (
    .mclk_i  (mclk_i),
    .por_n_i (por_n_i),
    .start_i (t_start),
    .busy_o  (t_busy),
    .done_o  (t_done)
  );

  // array strobes
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flash_erase_o <= 1'b0;
      flash_write_o <= 1'b0;
    end else begin
      flash_erase_o <= t_start && ctrl[B_PAGE_ERASE];
      flash_write_o <= t_start && ctrl[B_PAGE_WRITE];
    end
  end

  // section block follows the busy flag, so it too ignores the system reset
  always_ff @(posedge mclk_i or negedge por_n_i) begin
    if (!por_n_i) begin
      rww_block_o <= 1'b0;
    end else begin
      rww_block_o <= rww_busy;
    end
  end

  // sticky events, set wins over write-one clear
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_stat <= 3'h0;
      irq_o    <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~((do_write && aw_addr == OFF_IRQ_STAT) ? w_data[2:0] : 3'h0))
                  | {ev_expired, ev_refused, ev_done};
      irq_o    <= |(irq_stat & irq_mask);
    end
  end

  // read channel
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_arready_o <= 1'b0;
      s_rvalid_o  <= 1'b0;
      s_rdata_o   <= 32'h0;
      s_rresp_o   <= RESP_OKAY;
    end else begin
      s_arready_o <= !s_rvalid_o && !(s_arvalid_i && s_arready_o);
      if (s_arvalid_i && s_arready_o) begin
        s_rvalid_o <= 1'b1;
        s_rresp_o  <= RESP_OKAY;
        case (s_araddr_i)
          OFF_CTRL:     s_rdata_o <= {24'h0, 1'b0, rww_busy, 1'b0, ctrl[4:1],
                                      ctrl[0] || t_busy};
          OFF_ZPTR:     s_rdata_o <= {16'h0, zptr};
          OFF_EVENT:    s_rdata_o <= 32'h0;
          OFF_RESULT:   s_rdata_o <= {24'h0, result};
          OFF_FUSES:    s_rdata_o <= fuses;
          OFF_IRQ_STAT: s_rdata_o <= {29'h0, irq_stat};
          OFF_IRQ_MASK: s_rdata_o <= {29'h0, irq_mask};
          OFF_EEPROM:   s_rdata_o <= {31'h0, ee_pending};
          default: begin
            s_rdata_o <= 32'h0;
            s_rresp_o <= RESP_SLVERR;
          end
        endcase
      end else if (s_rready_i) begin
        s_rvalid_o <= 1'b0;
      end
    end
  end
endmodule // fsg_guard

// File: sim/fsg_flash_model.sv
// Purpose: program memory array seen by the guard block
// Assumes: erase/write strobes are one-cycle pulses
// Notes:   counts strobes so the bench can spot refused commands
`timescale 1ns/1ns
module fsg_flash_model #(
  parameter logic [7:0] DATA = 8'h96
) (
  input  wire logic       mclk_i,   // system clock
  input  wire logic       erase_i,  // page erase strobe
  input  wire logic       write_i,  // page write strobe
  input  wire logic       block_i,  // section unreadable
  output logic [7:0]      data_o,   // byte returned to a plain load
  output int              erases_o, // erase strobes seen
  output int              writes_o  // write strobes seen
);
  logic [7:0] junk;
  // a blocked section gives a changing pattern that steps through every byte value, the stored byte included
  always @(posedge mclk_i) begin
    junk <= junk + 8'h3b;
  end
  assign data_o = block_i ? junk : DATA;
  // strobe counters
  initial begin
    erases_o = 0;
    writes_o = 0;
    junk     = 8'h00;
  end
  always @(posedge mclk_i) begin
    if (erase_i) erases_o <= erases_o + 1;
    if (write_i) writes_o <= writes_o + 1;
  end
endmodule // fsg_flash_model

// File: sim/fsg_guard_checker.sv
// Purpose: port-level checks on the self-programming guard
// Assumes: default flash time of the package
// Notes:   flash checks stay alive across system reset
`timescale 1ns/1ns
module fsg_guard_checker
  import fsg_pkg::*;
(
  input wire logic mclk_i,        // system clock
  input wire logic resetn_i,      // system reset
  input wire logic por_n_i,       // power-on reset
  input wire logic s_awvalid_i,   // write address valid
  input wire logic s_awready_o,   // write address ready
  input wire logic s_wvalid_i,    // write data valid
  input wire logic s_wready_o,    // write data ready
  input wire logic s_bvalid_o,    // write response valid
  input wire logic s_arvalid_i,   // read address valid
  input wire logic s_arready_o,   // read address ready
  input wire logic s_rvalid_o,    // read data valid
  input wire logic flash_erase_o, // erase strobe
  input wire logic flash_write_o, // write strobe
  input wire logic rww_block_o,   // section unreadable
  input wire logic irq_o          // interrupt
);
  logic [19:0] cnt;
  // length of the current busy stretch; cleared when the block drops or at power-on, not by system reset
  always_ff @(posedge mclk_i or negedge por_n_i) begin
    if (!por_n_i) cnt <= 20'h0;
    else if (rww_block_o) cnt <= cnt + 20'h1;
    else cnt <= 20'h0;
  end
  erase_pulse_a: assert property (@(posedge mclk_i) disable iff (!por_n_i)
    flash_erase_o |=> !flash_erase_o) else $error("erase strobe longer than one cycle");
  write_pulse_a: assert property (@(posedge mclk_i) disable iff (!por_n_i)
    flash_write_o |=> !flash_write_o) else $error("write strobe longer than one cycle");
  start_blocks_a: assert property (@(posedge mclk_i) disable iff (!por_n_i)
    (flash_erase_o || flash_write_o) |=> rww_block_o [*8]) else $error("busy flag not held");
  no_restart_a: assert property (@(posedge mclk_i) disable iff (!por_n_i)
    rww_block_o && $past(rww_block_o) |-> !(flash_erase_o || flash_write_o))
    else $error("flash op started while busy");
  min_time_a: assert property (@(posedge mclk_i) disable iff (!por_n_i)
    $fell(rww_block_o) |-> cnt >= 20'(PROG_CYCLES - 1)) else $error("flash op too short");
  sys_reset_a: assert property (@(posedge mclk_i) disable iff (!por_n_i)
    !resetn_i && rww_block_o && cnt < 20'(PROG_CYCLES - 2) |=> rww_block_o)
    else $error("system reset aborted flash op");
  reset_quiet_a: assert property (@(posedge mclk_i) disable iff (!por_n_i)
    !resetn_i |-> !irq_o && !flash_erase_o && !flash_write_o) else $error("active in reset");
  one_strobe_a: assert property (@(posedge mclk_i) disable iff (!por_n_i)
    !(flash_erase_o && flash_write_o)) else $error("erase and write together");
  write_answer_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    s_awvalid_i && s_awready_o && s_wvalid_i && s_wready_o |-> ##[1:2] s_bvalid_o)
    else $error("write response late");
  read_answer_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    s_arvalid_i && s_arready_o |-> ##[1:2] s_rvalid_o) else $error("read data late");
endmodule // fsg_guard_checker
bind fsg_guard fsg_guard_checker u_chk (.mclk_i(mclk_i), .resetn_i(resetn_i),
  .por_n_i(por_n_i), .s_awvalid_i(s_awvalid_i), .s_awready_o(s_awready_o),
  .s_wvalid_i(s_wvalid_i), .s_wready_o(s_wready_o), .s_bvalid_o(s_bvalid_o),
  .s_arvalid_i(s_arvalid_i), .s_arready_o(s_arready_o), .s_rvalid_o(s_rvalid_o),
  .flash_erase_o(flash_erase_o), .flash_write_o(flash_write_o),
  .rww_block_o(rww_block_o), .irq_o(irq_o));

// File: sim/test_fsg_guard.sv
// Purpose: self-checking bench for the self-programming guard
// Assumes: response channels always ready; full flash time not awaited
// Notes:   readback pointers run from a table, odd cases by hand
`timescale 1ns/1ns
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module test_fsg_guard;
  import fsg_pkg::*;
  typedef struct { logic [15:0] ptr; logic [7:0] exp; } fsg_row_type;
  logic        mclk_i = 0, resetn_i = 0, por_n_i = 0;
  logic [7:0]  s_awaddr_i = 0, s_araddr_i = 0, flash_data_i;
  logic [31:0] s_wdata_i = 0, s_rdata_o, rdata;
  logic [3:0]  s_wstrb_i = 4'hf;
  logic        s_awvalid_i = 0, s_wvalid_i = 0, s_arvalid_i = 0;
  logic        s_bready_i = 1, s_rready_i = 1, s_awready_o, s_wready_o, s_arready_o;
  logic [1:0]  s_bresp_o, s_rresp_o, bresp, rresp;
  logic        s_bvalid_o, s_rvalid_o, flash_erase_o, flash_write_o, rww_block_o, irq_o;
  int          bad_count = 0, n_checks = 0, cyc = 0, erases, writes;
  fsg_row_type rows [5] = '{'{Z_FUSE_LOW, 8'h62}, '{Z_LOCK, 8'h3c},
    '{Z_FUSE_EXT, 8'hf9}, '{Z_FUSE_HIGH, 8'hdf}, '{16'h0007, UNDEF_READ}};
  fsg_guard uut (.*);
  fsg_flash_model #(.DATA(8'h96)) u_flash (.mclk_i(mclk_i), .erase_i(flash_erase_o),
    .write_i(flash_write_o), .block_i(rww_block_o), .data_o(flash_data_i),
    .erases_o(erases), .writes_o(writes));
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end
  // hang guard: whole run needs well under a thousand cycles
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_awaddr_i <= a;
    s_wdata_i <= d;
    s_awvalid_i <= 1'b1;
    s_wvalid_i <= 1'b1;
    forever begin
      @(posedge mclk_i);
      if (s_awvalid_i && s_awready_o) s_awvalid_i <= 1'b0;
      if (s_wvalid_i && s_wready_o) s_wvalid_i <= 1'b0;
      if (s_bvalid_o) begin
        bresp = s_bresp_o;
        break;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a);
    s_araddr_i <= a;
    s_arvalid_i <= 1'b1;
    forever begin
      @(posedge mclk_i);
      if (s_arvalid_i && s_arready_o) s_arvalid_i <= 1'b0;
      if (s_rvalid_o) begin
        rdata = s_rdata_o;
        rresp = s_rresp_o;
        break;
      end
    end
  endtask
  // timed command: control write then the cpu strobe right behind it
  // nothing else runs between the two writes, as with interrupts masked
  task automatic cmd(input logic [31:0] c, input logic [31:0] ev);
    wr(OFF_CTRL, c);
    wr(OFF_EVENT, ev);
  endtask
  initial begin
    repeat (16) @(posedge mclk_i);
    resetn_i <= 1'b1;
    por_n_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rd(OFF_FUSES);
    `CHK(rdata, 32'hffffffff)
    wr(OFF_FUSES, 32'h09df623c);
    // readback table; every row must also clear the command bits
    foreach (rows[i]) begin
      wr(OFF_ZPTR, {16'h0, rows[i].ptr});
      cmd(32'h09, 32'h1);
      rd(OFF_RESULT);
      `CHK(rdata[7:0], rows[i].exp)
      rd(OFF_CTRL);
      `CHK(rdata[3:0], 4'h0)
    end
    wr(OFF_EVENT, 32'h1);
    rd(OFF_RESULT);
    `CHK(rdata[7:0], 8'h96)
    // window runs out with no strobe
    wr(OFF_CTRL, 32'h09);
    repeat (8) @(posedge mclk_i);
    rd(OFF_CTRL);
    `CHK(rdata[3:0], 4'h0)
    rd(OFF_IRQ_STAT);
    `CHK(rdata[B_IRQ_EXPIRED], 1'b1)
    wr(OFF_IRQ_STAT, 32'h7);
    // eeprom busy: readback and erase both refused, irq raised then masked
    wr(OFF_IRQ_MASK, 32'h2);
    wr(OFF_EEPROM, 32'h1);
    cmd(32'h09, 32'h1);
    rd(OFF_CTRL);
    `CHK(rdata[3:0], 4'h0)
    rd(OFF_IRQ_STAT);
    `CHK(rdata[B_IRQ_REFUSED], 1'b1)
    repeat (2) @(posedge mclk_i);
    `CHK(irq_o, 1'b1)
    cmd(32'h03, 32'h2);
    repeat (4) @(posedge mclk_i);
    `CHK(erases, 0)
    wr(OFF_IRQ_MASK, 32'h0);
    repeat (2) @(posedge mclk_i);
    `CHK(irq_o, 1'b0)
    wr(OFF_IRQ_STAT, 32'h7);
    wr(OFF_EEPROM, 32'h0);
    // page erase starts; a second command while busy is ignored
    cmd(32'h03, 32'h2);
    repeat (2) @(posedge mclk_i);
    `CHK(erases, 1)
    `CHK(rww_block_o, 1'b1)
    rd(OFF_CTRL);
    `CHK(rdata[B_RWW_BUSY], 1'b1)
    cmd(32'h05, 32'h2);
    repeat (4) @(posedge mclk_i);
    `CHK(writes, 0)
    // system reset must not cut the running erase short
    resetn_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    `CHK(rww_block_o, 1'b1)
    rd(OFF_CTRL);
    `CHK(rdata[B_RWW_BUSY], 1'b1)
    // power-on reset aborts it; then a page write goes through
    por_n_i <= 1'b0;
    resetn_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    por_n_i <= 1'b1;
    resetn_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    `CHK(rww_block_o, 1'b0)
    rd(OFF_EEPROM);
    `CHK(rdata[0], 1'b0)
    rd(OFF_CTRL);
    `CHK(rdata[B_SELFPROG_ENABLE], 1'b0)
    cmd(32'h05, 32'h2);
    repeat (2) @(posedge mclk_i);
    `CHK(writes, 1)
    // re-enable while the write still runs leaves the section blocked
    cmd(32'h11, 32'h2);
    repeat (2) @(posedge mclk_i);
    `CHK(rww_block_o, 1'b1)
    // unmapped places
    rd(8'h20);
    `CHK(rresp, RESP_SLVERR)
    `CHK(rdata, 32'h0)
    wr(8'h24, 32'h1);
    `CHK(bresp, RESP_SLVERR)
    end_sim();
  end
endmodule // test_fsg_guard
